// ===== hw/ddc_channel_config_decode.sv
// configuration decode and output pacing for one downconverter channel
// assumes samples from both converter cores arrive together on inValid,
// and the register master follows the single-cycle strobe protocol.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "ddc_cfg_defs.svh"
module ddc_channel_config_decode (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  // register port
  input  wire logic [11:0]            regAddr,
  input  wire logic [7:0]             regWdata,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic [7:0]                  regRdata,
  // converter samples
  input  wire logic                   inValid,
  input  wire ddc_cfg_pkg::samp_pair_t chanA,
  input  wire ddc_cfg_pkg::samp_pair_t chanB,
  // toward framer
  output ddc_cfg_pkg::out_pair_t      outData,
  output logic                        outValid,
  output logic                        outQValid,
  // decoded configuration
  output logic                        complexMixer,
  output ddc_cfg_pkg::if_mode_t       ifMode,
  output logic [6:0]                  filterChain,
  output logic [5:0]                  decimRatio,
  output logic                        rateIllegal
);
  logic [7:0] ctrl_ff;
  logic [7:0] insel_ff;
  logic [5:0] cnt_ff;
  ddc_cfg_pkg::run_state_t state_ff;
  ddc_cfg_pkg::out_pair_t  out_ff;
  logic       vld_ff;
  logic       qvld_ff;
  logic [7:0] rd_ff;

  wire selCtrl  = (regAddr == `ADDR_CONTROL);
  wire selInsel = (regAddr == `ADDR_INPUT_RATE);
  wire selStat  = (regAddr == `ADDR_STATUS);

  wire       c2r     = ctrl_ff[`BIT_C2R];
  wire [2:0] decCode = ctrl_ff[2:0];
  wire [3:0] extCode = insel_ff[7:4];
  wire       useExt  = (decCode == `DEC_EXTENDED);

  // chain bits: {tb1, fb2, tb2, hb4, hb3, hb2, hb1}; ratio is the complex count
  logic [6:0] priChain;
  logic [5:0] priRatio;
  always_comb begin
    case (decCode)
      3'h0:    begin priChain = 7'h03; priRatio = 6'd4;  end
      3'h1:    begin priChain = 7'h07; priRatio = 6'd8;  end
      3'h2:    begin priChain = 7'h0F; priRatio = 6'd16; end
      3'h3:    begin priChain = 7'h01; priRatio = 6'd2;  end
      3'h4:    begin priChain = 7'h11; priRatio = 6'd6;  end
      3'h5:    begin priChain = 7'h13; priRatio = 6'd12; end
      3'h6:    begin priChain = 7'h17; priRatio = 6'd24; end
      default: begin priChain = 7'h00; priRatio = 6'd0;  end
    endcase
  end

  logic [6:0] extChain;
  logic [5:0] extRatio;
  logic       extNoHalf;
  always_comb begin
    extNoHalf = 1'b0;
    case (extCode)
      4'h0:    begin extChain = 7'h1F; extRatio = 6'd48; end
      4'h2:    begin extChain = 7'h21; extRatio = 6'd10; end
      4'h3:    begin extChain = 7'h23; extRatio = 6'd20; end
      4'h4:    begin extChain = 7'h27; extRatio = 6'd40; end
      4'h7:    begin extChain = 7'h40; extRatio = 6'd3;  extNoHalf = 1'b1; end
      4'h8:    begin extChain = 7'h60; extRatio = 6'd15; extNoHalf = 1'b1; end
      4'h9:    begin extChain = 7'h62; extRatio = 6'd30; extNoHalf = 1'b1; end
      default: begin extChain = 7'h00; extRatio = 6'd0;  end
    endcase
  end

  // chains without hb1 cannot be halved; flag rather than guess a rate
  wire [5:0] fullRatio = useExt ? extRatio : priRatio;
  wire       badPair   = useExt & extNoHalf & c2r;
  wire       badCode   = (fullRatio == `RATIO_ILLEGAL);
  wire [5:0] effRatio  = c2r ? {1'b0, fullRatio[5:1]} : fullRatio;
  assign filterChain = useExt ? extChain : priChain;
  assign rateIllegal = badPair | badCode;
  assign decimRatio  = rateIllegal ? `RATIO_ILLEGAL : effRatio;
  assign complexMixer = ctrl_ff[`BIT_MIXER];
  assign ifMode      = ddc_cfg_pkg::if_mode_t'(ctrl_ff[5:4]);

  // source muxing; a real mixer takes both paths from the in-phase channel
  wire [13:0] srcI  = insel_ff[`BIT_ISRC] ? chanB.sampI : chanA.sampI;
  wire [13:0] srcQc = insel_ff[`BIT_QSRC] ? chanB.sampQ : chanA.sampQ;
  wire [13:0] srcQ  = complexMixer ? srcQc : srcI;
  wire [15:0] extI  = {{2{srcI[13]}}, srcI};
  wire [15:0] extQ  = {{2{srcQ[13]}}, srcQ};
  wire [15:0] gainI = ctrl_ff[`BIT_GAIN] ? {extI[14:0], 1'b0} : extI;
  wire [15:0] gainQ = ctrl_ff[`BIT_GAIN] ? {extQ[14:0], 1'b0} : extQ;

  wire cntWrap = (cnt_ff >= decimRatio - 6'd1);
  wire fire    = inValid & (state_ff == ddc_cfg_pkg::ST_RUN) & cntWrap;

  // any config write restarts the pacing so ratios never straddle settings
  wire cfgWrite = regWr & (selCtrl | selInsel);
  ddc_cfg_pkg::run_state_t nxt_state;
  always_comb begin
    case (state_ff)
      ddc_cfg_pkg::ST_IDLE: nxt_state = rateIllegal ? ddc_cfg_pkg::ST_IDLE : ddc_cfg_pkg::ST_RUN;
      ddc_cfg_pkg::ST_RUN:  nxt_state = (rateIllegal | cfgWrite) ? ddc_cfg_pkg::ST_IDLE
                                                                  : ddc_cfg_pkg::ST_RUN;
      default:              nxt_state = ddc_cfg_pkg::ST_IDLE;
    endcase
  end

  wire [5:0] nxt_cnt = (state_ff != ddc_cfg_pkg::ST_RUN) ? 6'd0 :
                       !inValid ? cnt_ff : (cntWrap ? 6'd0 : cnt_ff + 6'd1);

  wire [7:0] nxt_rd = selCtrl  ? ctrl_ff :
                      selInsel ? (insel_ff & `INSEL_RW_MASK) :
                      selStat  ? {1'b0, rateIllegal, decimRatio} : 8'h00;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_ff  <= `CTRL_RESET;
      insel_ff <= `INSEL_RESET;
    end else if (regWr) begin
      if (selCtrl)  ctrl_ff  <= regWdata;
      if (selInsel) insel_ff <= regWdata & `INSEL_RW_MASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ddc_cfg_pkg::ST_IDLE;
      cnt_ff   <= 6'd0;
      rd_ff    <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      rd_ff    <= regRd ? nxt_rd : 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      out_ff  <= '0;
      vld_ff  <= 1'b0;
      qvld_ff <= 1'b0;
    end else begin
      vld_ff  <= fire;
      qvld_ff <= fire & ~c2r;
      if (fire) begin
        out_ff.outI <= gainI;
        out_ff.outQ <= c2r ? 16'h0000 : gainQ;
      end
    end
  end

  assign outData   = out_ff;
  assign outValid  = vld_ff;
  assign outQValid = qvld_ff;
  assign regRdata  = rd_ff;

  // checks
  property p_qvalid_only_complex;
    @(posedge clk_sys) disable iff (!rst_b) outQValid |-> (outValid && !$past(c2r));
  endproperty
  a_qvalid_only_complex: assert property (p_qvalid_only_complex)
    else $error("q valid with real-only output");

  property p_c2r_halves;
    @(posedge clk_sys) disable iff (!rst_b) (c2r && !rateIllegal) |-> decimRatio == fullRatio/2;
  endproperty
  a_c2r_halves: assert property (p_c2r_halves)
    else $error("real-only ratio not half");

  property p_code0;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h0) |-> decimRatio == (c2r ? 6'd2 : 6'd4);
  endproperty
  a_code0: assert property (p_code0)
    else $error("code 000 ratio wrong");

  property p_code6;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h6) |-> decimRatio == (c2r ? 6'd12 : 6'd24);
  endproperty
  a_code6: assert property (p_code6)
    else $error("code 110 ratio wrong");

  property p_ext_ignored;
    @(posedge clk_sys) disable iff (!rst_b)
      (!useExt && $changed(extCode) && $stable(decCode) && $stable(c2r)) |-> $stable(decimRatio);
  endproperty
  a_ext_ignored: assert property (p_ext_ignored)
    else $error("extended field leaked");

  property p_ext0;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && extCode == 4'h0) |-> decimRatio == (c2r ? 6'd24 : 6'd48);
  endproperty
  a_ext0: assert property (p_ext0)
    else $error("extended 0 ratio wrong");

  property p_odd_illegal;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && c2r && (extCode == 4'h7 || extCode == 4'h8 || extCode == 4'h9)) |-> rateIllegal;
  endproperty
  a_odd_illegal: assert property (p_odd_illegal)
    else $error("unsupported odd rate not flagged");

  property p_ext9;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && !c2r && extCode == 4'h9) |-> decimRatio == 6'd30 && filterChain == 7'h62;
  endproperty
  a_ext9: assert property (p_ext9)
    else $error("extended 9 decode wrong");

  property p_real_mixer_q;
    @(posedge clk_sys) disable iff (!rst_b) (fire && !complexMixer && !c2r) |=> outData.outQ == outData.outI;
  endproperty
  a_real_mixer_q: assert property (p_real_mixer_q)
    else $error("real mixer q differs");

  property p_pace;
    @(posedge clk_sys) disable iff (!rst_b) outValid |-> !$past(outValid) || $past(decimRatio) == 6'd1;
  endproperty
  a_pace: assert property (p_pace)
    else $error("valid too dense");

  property p_chain0;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h0) |-> filterChain == 7'h03;
  endproperty
  a_chain0: assert property (p_chain0)
    else $error("code 000 chain wrong");

  property p_code1;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h1) |-> decimRatio == (c2r ? 6'd4 : 6'd8) && filterChain == 7'h07;
  endproperty
  a_code1: assert property (p_code1)
    else $error("code 001 decode wrong");

  property p_code2;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h2) |-> decimRatio == (c2r ? 6'd8 : 6'd16) && filterChain == 7'h0F;
  endproperty
  a_code2: assert property (p_code2)
    else $error("code 010 decode wrong");

  property p_code3;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h3) |-> decimRatio == (c2r ? 6'd1 : 6'd2) && filterChain == 7'h01;
  endproperty
  a_code3: assert property (p_code3)
    else $error("code 011 decode wrong");

  property p_code4;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h4) |-> decimRatio == (c2r ? 6'd3 : 6'd6) && filterChain == 7'h11;
  endproperty
  a_code4: assert property (p_code4)
    else $error("code 100 decode wrong");

  property p_code5;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h5) |-> decimRatio == (c2r ? 6'd6 : 6'd12) && filterChain == 7'h13;
  endproperty
  a_code5: assert property (p_code5)
    else $error("code 101 decode wrong");

  property p_chain6;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode == 3'h6) |-> filterChain == 7'h17;
  endproperty
  a_chain6: assert property (p_chain6)
    else $error("code 110 chain wrong");

  property p_ext_unlisted;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && extCode == 4'h1) |-> rateIllegal && decimRatio == 6'd0;
  endproperty
  a_ext_unlisted: assert property (p_ext_unlisted)
    else $error("unlisted extended code accepted");

  property p_primary_legal;
    @(posedge clk_sys) disable iff (!rst_b)
      (decCode != 3'h7) |-> !rateIllegal;
  endproperty
  a_primary_legal: assert property (p_primary_legal)
    else $error("primary code flagged illegal");

  property p_chain_ext0;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && extCode == 4'h0) |-> filterChain == 7'h1F;
  endproperty
  a_chain_ext0: assert property (p_chain_ext0)
    else $error("extended 0 chain wrong");

  property p_ext2;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && extCode == 4'h2) |-> decimRatio == (c2r ? 6'd5 : 6'd10) && filterChain == 7'h21;
  endproperty
  a_ext2: assert property (p_ext2)
    else $error("extended 2 decode wrong");

  property p_ext3;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && extCode == 4'h3) |-> decimRatio == (c2r ? 6'd10 : 6'd20) && filterChain == 7'h23;
  endproperty
  a_ext3: assert property (p_ext3)
    else $error("extended 3 decode wrong");

  property p_ext4;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && extCode == 4'h4) |-> decimRatio == (c2r ? 6'd20 : 6'd40) && filterChain == 7'h27;
  endproperty
  a_ext4: assert property (p_ext4)
    else $error("extended 4 decode wrong");

  property p_ext7;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && !c2r && extCode == 4'h7) |-> decimRatio == 6'd3 && filterChain == 7'h40;
  endproperty
  a_ext7: assert property (p_ext7)
    else $error("extended 7 decode wrong");

  property p_ext8;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && !c2r && extCode == 4'h8) |-> decimRatio == 6'd15 && filterChain == 7'h60;
  endproperty
  a_ext8: assert property (p_ext8)
    else $error("extended 8 decode wrong");

  property p_ext9_real;
    @(posedge clk_sys) disable iff (!rst_b)
      (useExt && c2r && extCode == 4'h9) |-> rateIllegal && decimRatio == 6'd0;
  endproperty
  a_ext9_real: assert property (p_ext9_real)
    else $error("extended 9 real-only not refused");

  property p_gain_double;
    @(posedge clk_sys) disable iff (!rst_b)
      (fire && ctrl_ff[`BIT_GAIN]) |=> outData.outI == {$past(srcI[13]), $past(srcI), 1'b0};
  endproperty
  a_gain_double: assert property (p_gain_double)
    else $error("doubled sample wrong");

  property p_gain_unity;
    @(posedge clk_sys) disable iff (!rst_b)
      (fire && !ctrl_ff[`BIT_GAIN]) |=> outData.outI == {{2{$past(srcI[13])}}, $past(srcI)};
  endproperty
  a_gain_unity: assert property (p_gain_unity)
    else $error("unity sample wrong");

  property p_qsrc_a;
    @(posedge clk_sys) disable iff (!rst_b)
      (fire && complexMixer && !c2r && !ctrl_ff[`BIT_GAIN] && !insel_ff[`BIT_QSRC])
        |=> outData.outQ == {{2{$past(chanA.sampQ[13])}}, $past(chanA.sampQ)};
  endproperty
  a_qsrc_a: assert property (p_qsrc_a)
    else $error("q source a not routed");

  property p_isrc_b;
    @(posedge clk_sys) disable iff (!rst_b)
      (fire && !ctrl_ff[`BIT_GAIN] && insel_ff[`BIT_ISRC])
        |=> outData.outI == {{2{$past(chanB.sampI[13])}}, $past(chanB.sampI)};
  endproperty
  a_isrc_b: assert property (p_isrc_b)
    else $error("i source b not routed");

  property p_real_only_q;
    @(posedge clk_sys) disable iff (!rst_b)
      (fire && c2r) |=> outData.outQ == 16'h0000 && !outQValid && outValid;
  endproperty
  a_real_only_q: assert property (p_real_only_q)
    else $error("real-only q not quiet");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_b) !fire |=> $stable(outData) && !outValid;
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved without strobe");

  c_fire_complex: cover property (@(posedge clk_sys) disable iff (!rst_b) fire && !c2r);
  c_fire_real:    cover property (@(posedge clk_sys) disable iff (!rst_b) fire && c2r);
  c_ext_used:     cover property (@(posedge clk_sys) disable iff (!rst_b) useExt && outValid);
  c_illegal:      cover property (@(posedge clk_sys) disable iff (!rst_b) rateIllegal);
  c_gain_out:     cover property (@(posedge clk_sys) disable iff (!rst_b) fire && ctrl_ff[`BIT_GAIN]);
endmodule : ddc_channel_config_decode

// ===== hw/ddc_cfg_defs.svh
// register offsets, field positions, reset values and rate codes for the
// second downconverter channel configuration decode; included by bare name.
`ifndef DDC_CFG_DEFS_SVH
`define DDC_CFG_DEFS_SVH
`define ADDR_CONTROL      12'h0330
`define ADDR_INPUT_RATE   12'h0331
`define ADDR_STATUS       12'h0338
`define CTRL_RESET        8'h00
`define INSEL_RESET       8'h05
`define INSEL_RW_MASK     8'hF5
`define BIT_MIXER         7
`define BIT_GAIN          6
`define BIT_C2R           3
`define BIT_QSRC          2
`define BIT_ISRC          0
`define DEC_EXTENDED      3'h7
`define RATIO_ILLEGAL     6'h00
`endif

// ===== hw/ddc_cfg_pkg.sv
// types for the downconverter channel configuration decode
package ddc_cfg_pkg;
  typedef enum logic [1:0] {
    IF_VARIABLE = 2'h0,
    IF_ZERO     = 2'h1,
    IF_QUARTER  = 2'h2,
    IF_TEST     = 2'h3
  } if_mode_t;
  typedef struct packed {
    logic [13:0] sampI;
    logic [13:0] sampQ;
  } samp_pair_t;
  typedef struct packed {
    logic [15:0] outI;
    logic [15:0] outQ;
  } out_pair_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } run_state_t;
endpackage : ddc_cfg_pkg

// ===== verif/ddc_conv_model.sv
// converter core pair stand-in: steady samples while enabled
// assumes one sample clock shared with the channel under test
`timescale 1ns/1ps
module ddc_conv_model (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  // control from bench
  input  wire logic                en,
  input  wire logic [13:0]         lvlA,
  input  wire logic [13:0]         lvlB,
  // samples toward channel
  output ddc_cfg_pkg::samp_pair_t  chanA,
  output ddc_cfg_pkg::samp_pair_t  chanB,
  output logic                     inValid
);
  logic [13:0] junk_ff;
  // idle lines churn so a stale sample is never taken for a real one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      junk_ff <= 14'h0000;
      inValid <= 1'b0;
    end else begin
      junk_ff <= junk_ff + 14'h0155;
      inValid <= en;
    end
  end
  assign chanA = inValid ? {lvlA, lvlA} : {junk_ff, ~junk_ff};
  assign chanB = inValid ? {lvlB, lvlB} : {~junk_ff, junk_ff};
endmodule : ddc_conv_model

// ===== verif/ddc_channel_config_decode_tb.sv
// self-checking bench for the channel configuration decode
// assumes the converter model feeds a sample every cycle once enabled
`timescale 1ns/1ps
module ddc_channel_config_decode_tb;
  logic                     clk_sys, rst_b, regWr, regRd, en, inValid;
  logic                     outValid, outQValid, complexMixer, rateIllegal;
  logic [11:0]              regAddr;
  logic [7:0]               regWdata, regRdata;
  logic [6:0]               filterChain;
  logic [5:0]               decimRatio;
  logic [13:0]              lvlA, lvlB;
  ddc_cfg_pkg::samp_pair_t  chanA, chanB;
  ddc_cfg_pkg::out_pair_t   outData;
  ddc_cfg_pkg::if_mode_t    ifMode;
  int                       error_cnt, compares, cyc;
  // {chain, ratio} primary; {code, chain, ratio} extended, complex ratios
  logic [12:0] pTab [0:6] = '{13'h00C4, 13'h01C8, 13'h03D0, 13'h0042, 13'h0446,
                              13'h04CC, 13'h05D8};
  logic [16:0] xTab [0:6] = '{17'h0_07F0, 17'h0_484A, 17'h0_68D4, 17'h0_89E8,
                              17'h0_F003, 17'h1_180F, 17'h1_389E};

  ddc_conv_model src (.clk_sys(clk_sys), .rst_b(rst_b), .en(en), .lvlA(lvlA),
    .lvlB(lvlB), .chanA(chanA), .chanB(chanB), .inValid(inValid));
  ddc_channel_config_decode uut (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .inValid(inValid), .chanA(chanA), .chanB(chanB), .outData(outData),
    .outValid(outValid), .outQValid(outQValid), .complexMixer(complexMixer),
    .ifMode(ifMode), .filterChain(filterChain), .decimRatio(decimRatio),
    .rateIllegal(rateIllegal));

  task end_of_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    @(negedge clk_sys);
    chk(regRdata, e);
  endtask : rd

  task regs();
    rd(12'h0330, 8'h00);
    rd(12'h0331, 8'h05);
    rd(12'h0338, 8'h04);
    wr(12'h0332, 8'hFF);
    rd(12'h0332, 8'h00);
    rd(12'h0330, 8'h00);
    wr(12'h0331, 8'hFF);
    rd(12'h0331, 8'hF5);
    for (int m = 0; m < 4; m++) begin
      wr(12'h0330, {2'b10, m[1:0], 4'h0});
      @(negedge clk_sys);
      chk(complexMixer, 1'b1);
      chk(ifMode, m[1:0]);
    end
    wr(12'h0330, 8'h30);
    @(negedge clk_sys);
    chk(complexMixer, 1'b0);
  endtask : regs

  task decode_tables();
    logic bad;
    for (int i = 0; i < 7; i++) for (int c = 0; c < 2; c++) begin
      wr(12'h0330, {4'h0, c[0], i[2:0]});
      @(negedge clk_sys);
      chk(decimRatio, pTab[i][5:0] >> c);
      chk(filterChain, pTab[i][12:6]);
    end
    for (int i = 0; i < 7; i++) for (int c = 0; c < 2; c++) begin
      wr(12'h0331, {xTab[i][16:13], 4'h5});
      wr(12'h0330, {4'h0, c[0], 3'h7});
      @(negedge clk_sys);
      bad = (c == 1) && (i > 3);
      chk(rateIllegal, bad);
      chk(decimRatio, bad ? 6'h00 : xTab[i][5:0] >> c);
      if (!bad) chk(filterChain, xTab[i][12:6]);
    end
    wr(12'h0331, 8'h25);
    wr(12'h0330, 8'h00);
    @(negedge clk_sys);
    chk(decimRatio, 6'h04);
  endtask : decode_tables

  // interval between output strobes with a sample every cycle equals N
  task pace(input logic [7:0] ctl, input int n, input logic qv, input logic [31:0] ed);
    int k;
    wr(12'h0330, ctl);
    repeat (2) @(negedge clk_sys);
    k = 0;
    while (outValid !== 1'b1 && k < 100) begin
      @(negedge clk_sys);
      k++;
    end
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (outValid !== 1'b1 && k < 100);
    chk(k, n);
    chk(outQValid, qv);
    chk(outData, ed);
  endtask : pace

  task no_out();
    int hits;
    for (int j = 7; j < 10; j++) begin
      wr(12'h0331, {j[3:0], 4'h4});
      wr(12'h0330, 8'h0F);
      hits = 0;
      repeat (60) begin
        @(negedge clk_sys);
        if (outValid === 1'b1) hits++;
      end
      chk(hits, 0);
    end
  endtask : no_out

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    {rst_b, regWr, regRd, en, regAddr, regWdata} = '0;
    lvlA = 14'h2001;
    lvlB = 14'h0123;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    regs();
    decode_tables();
    wr(12'h0331, 8'h05);
    en <= 1'b1;
    pace(8'h00, 4, 1'b1, 32'h0123_0123);
    pace(8'h4B, 1, 1'b0, 32'h0246_0000);
    wr(12'h0331, 8'h00);
    pace(8'h81, 8, 1'b1, 32'hE001_E001);
    wr(12'h0331, 8'h04);
    pace(8'h87, 48, 1'b1, 32'hE001_0123);
    wr(12'h0331, 8'h24);
    pace(8'h0F, 5, 1'b0, 32'hE001_0000);
    no_out();
    end_of_test();
  end
endmodule : ddc_channel_config_decode_tb
